// ### core/rda_aligner.sv
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
// Behaviour
// - Delay one chosen path, reference or microphone, by 0 to 2400 samples.
// - Applied delay comes from own estimate or a host fixed value.
// - Three modes: automatic, manual, start-up once; start-up after reset.
// - Automatic mode starts at once and re-estimates continuously, updating the delay.
// - Manual mode lets an estimate begun in start-up mode finish, then idles until a host trigger: estimate now or apply fixed.
// - Manual delay holds until new fixed value, new estimate, or automatic mode.
// - Start-up mode estimates once right after start and applies it.
// - After start-up estimate the delay holds unless triggered or automatic selected.
module rda_aligner import rda_pkg::*; #(
	parameter int unsigned DEPTH = 4096
) (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              in_valid,
	output logic                   in_ready,
	input  wire rda_pair_t         in_pair,
	output logic                   out_valid,
	input  wire logic              out_ready,
	output rda_pair_t              out_pair
);

	localparam int unsigned PTR_W = $clog2(DEPTH);

	if (DEPTH < MAX_DELAY_SAMPLES + 1 || (1 << PTR_W) != DEPTH) begin : g_depth_check
		$error("DEPTH must be a power of two above the longest delay");
	end

	typedef enum logic [2:0] {
		EST_IDLE,
		EST_QUIET,
		EST_ARMED,
		EST_MEASURE,
		EST_DONE
	} rda_est_state_t;

	logic                aw_have_q;
	logic                aw_have_d;
	logic [ADDR_W-1:0]   aw_addr_q;
	logic                w_have_q;
	logic                w_have_d;
	logic [31:0]         w_data_q;
	logic [3:0]          w_strb_q;
	logic                awready_q;
	logic                wready_q;
	logic                bvalid_q;
	logic [1:0]          bresp_q;
	logic                arready_q;
	logic                rvalid_q;
	logic [31:0]         rdata_q;
	logic [1:0]          rresp_q;
	logic                wr_fire;
	logic [31:0]         rd_word;
	logic                rd_hit;
	logic [1:0]          mode_q;
	logic                fix_path_q;
	logic [DLY_W-1:0]    fixed_q;
	logic [SAMPLE_W-1:0] level_q;
	logic [DLY_W-1:0]    quiet_len_q;
	logic                trig_est_q;
	logic                trig_fix_q;
	logic                fix_wr_q;
	logic                auto_enter_q;
	logic                halt_q;
	logic                boot_q;
	logic [31:0]         wmerged;
	rda_est_state_t      est_q;
	logic [DLY_W-1:0]    cnt_q;
	logic                leader_mic_q;
	logic                est_ever_q;
	logic                tmo_q;
	logic                est_start;
	logic [DLY_W-1:0]    dly_q;
	logic                path_q;
	logic [PTR_W-1:0]    wr_ptr_q;
	logic [DLY_W-1:0]    fill_q;
	rda_pair_t           hist [DEPTH];
	rda_pair_t           past;
	rda_pair_t           delayed;
	rda_pair_t           aligned;
	logic                buf_ready;
	logic                stb;
	logic                on_ref;
	logic                on_mic;

	function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	function automatic logic [SAMPLE_W-1:0] mag(input logic [SAMPLE_W-1:0] v);
		return v[SAMPLE_W-1] ? SAMPLE_W'(~v + 16'h0001) : v;
	endfunction : mag

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign in_ready      = buf_ready;
	assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;
	assign stb           = in_valid && buf_ready;

	// ****************************************************************
	// AXI4-Lite write channels
	// ****************************************************************
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d  = w_have_q;
		if (s_axi_awvalid && awready_q) begin
			aw_have_d = 1'b1;
		end
		if (s_axi_wvalid && wready_q) begin
			w_have_d = 1'b1;
		end
		if (wr_fire) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awready_q <= !aw_have_d;
			wready_q  <= !w_have_d;
			if (s_axi_awvalid && awready_q) begin
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_q) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			if (aw_addr_q == REG_CTRL || aw_addr_q == REG_FIXED || aw_addr_q == REG_TRIGGER ||
				aw_addr_q == REG_LEVEL || aw_addr_q == REG_QUIET) begin
				bresp_q <= RESP_OKAY;
			end else begin
				bresp_q <= RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	always_comb begin
		wmerged = '0;
		if (aw_addr_q == REG_CTRL) begin
			wmerged = merge({29'h0, fix_path_q, mode_q}, w_data_q, w_strb_q);
		end else if (aw_addr_q == REG_FIXED) begin
			wmerged = merge({20'h0, fixed_q}, w_data_q, w_strb_q);
		end else if (aw_addr_q == REG_LEVEL) begin
			wmerged = merge({16'h0, level_q}, w_data_q, w_strb_q);
		end else if (aw_addr_q == REG_QUIET) begin
			wmerged = merge({20'h0, quiet_len_q}, w_data_q, w_strb_q);
		end else if (aw_addr_q == REG_TRIGGER) begin
			wmerged = merge(32'h0, w_data_q, w_strb_q);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_q       <= MODE_STARTUP;
			fix_path_q   <= PATH_REF;
			fixed_q      <= FIXED_RST;
			level_q      <= LEVEL_RST;
			quiet_len_q  <= QUIET_RST;
			trig_est_q   <= 1'b0;
			trig_fix_q   <= 1'b0;
			fix_wr_q     <= 1'b0;
			auto_enter_q <= 1'b0;
			halt_q       <= 1'b0;
		end else begin
			trig_est_q   <= 1'b0;
			trig_fix_q   <= 1'b0;
			fix_wr_q     <= 1'b0;
			auto_enter_q <= 1'b0;
			halt_q       <= 1'b0;
			if (wr_fire && aw_addr_q == REG_CTRL) begin
				fix_path_q <= wmerged[CTRL_PATH_BIT];
				if (wmerged[CTRL_MODE_LSB +: 2] != 2'h3) begin
					mode_q       <= wmerged[CTRL_MODE_LSB +: 2];
					auto_enter_q <= wmerged[CTRL_MODE_LSB +: 2] == MODE_AUTO && mode_q != MODE_AUTO;
					halt_q       <= wmerged[CTRL_MODE_LSB +: 2] != MODE_AUTO && mode_q == MODE_AUTO;
				end
			end else if (wr_fire && aw_addr_q == REG_FIXED) begin
				fixed_q  <= wmerged[DLY_W-1:0];
				fix_wr_q <= 1'b1;
			end else if (wr_fire && aw_addr_q == REG_LEVEL) begin
				level_q <= wmerged[SAMPLE_W-1:0];
			end else if (wr_fire && aw_addr_q == REG_QUIET) begin
				quiet_len_q <= wmerged[DLY_W-1:0];
			end else if (wr_fire && aw_addr_q == REG_TRIGGER) begin
				trig_est_q <= wmerged[TRIG_EST_BIT];
				trig_fix_q <= wmerged[TRIG_FIX_BIT];
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite read channels
	// ****************************************************************
	always_comb begin
		rd_word = '0;
		rd_hit  = 1'b1;
		if (s_axi_araddr == REG_CTRL) begin
			rd_word = {29'h0, fix_path_q, mode_q};
		end else if (s_axi_araddr == REG_FIXED) begin
			rd_word = {20'h0, fixed_q};
		end else if (s_axi_araddr == REG_TRIGGER) begin
			rd_word = '0;
		end else if (s_axi_araddr == REG_LEVEL) begin
			rd_word = {16'h0, level_q};
		end else if (s_axi_araddr == REG_QUIET) begin
			rd_word = {20'h0, quiet_len_q};
		end else if (s_axi_araddr == REG_STATUS) begin
			rd_word[STAT_DLY_LSB +: DLY_W] = dly_q;
			rd_word[STAT_PATH_BIT]         = path_q;
			rd_word[STAT_BUSY_BIT]         = est_q != EST_IDLE;
			rd_word[STAT_VALID_BIT]        = est_ever_q;
			rd_word[STAT_TMO_BIT]          = tmo_q;
			rd_word[STAT_MODE_LSB +: 2]    = mode_q;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_word;
			rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end
	end

	// ****************************************************************
	// Offset estimator
	// ****************************************************************
	assign on_ref    = mag(in_pair.echo_ref) >= level_q;
	assign on_mic    = mag(in_pair.mic) >= level_q;
	assign est_start = boot_q || trig_est_q || auto_enter_q;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			boot_q <= 1'b1;
		end else begin
			boot_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			est_q        <= EST_IDLE;
			cnt_q        <= '0;
			leader_mic_q <= 1'b0;
			tmo_q        <= 1'b0;
		end else if (est_start) begin
			est_q <= EST_QUIET;
			cnt_q <= '0;
			tmo_q <= 1'b0;
		end else if (halt_q) begin
			est_q <= EST_IDLE;
		end else begin
			case (est_q)
				EST_IDLE: begin
				end
				EST_QUIET: begin
					if (stb) begin
						cnt_q <= (on_ref || on_mic) ? '0 : DLY_W'(cnt_q + 12'h001);
						if (!on_ref && !on_mic && DLY_W'(cnt_q + 12'h001) >= quiet_len_q) begin
							est_q <= EST_ARMED;
						end
					end
				end
				EST_ARMED: begin
					if (stb && (on_ref || on_mic)) begin
						cnt_q        <= '0;
						leader_mic_q <= on_mic && !on_ref;
						est_q        <= (on_ref && on_mic) ? EST_DONE : EST_MEASURE;
					end
				end
				EST_MEASURE: begin
					if (stb) begin
						cnt_q <= DLY_W'(cnt_q + 12'h001);
						if (leader_mic_q ? on_ref : on_mic) begin
							est_q <= EST_DONE;
						end else if (DLY_W'(cnt_q + 12'h001) >= DLY_W'(MAX_DELAY_SAMPLES)) begin
							tmo_q <= 1'b1;
							cnt_q <= '0;
							est_q <= EST_QUIET;
						end
					end
				end
				EST_DONE: begin
					cnt_q <= '0;
					est_q <= (mode_q == MODE_AUTO) ? EST_QUIET : EST_IDLE;
				end
				default: begin
					est_q <= EST_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Applied delay
	// ****************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dly_q      <= '0;
			path_q     <= PATH_REF;
			est_ever_q <= 1'b0;
		end else if (trig_fix_q || (fix_wr_q && mode_q == MODE_MANUAL)) begin
			dly_q  <= (fixed_q > DLY_W'(MAX_DELAY_SAMPLES)) ? DLY_W'(MAX_DELAY_SAMPLES) : fixed_q;
			path_q <= fix_path_q;
		end else if (est_q == EST_DONE && !est_start && !halt_q) begin
			dly_q      <= (leader_mic_q || cnt_q != '0) ? cnt_q : '0;
			path_q     <= leader_mic_q ? PATH_MIC : PATH_REF;
			est_ever_q <= 1'b1;
		end
	end

	// ****************************************************************
	// Sample history
	// ****************************************************************
	// delay storage
	always_ff @(posedge mclk) begin
		if (stb) begin
			hist[wr_ptr_q] <= in_pair;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= '0;
			fill_q   <= '0;
		end else if (stb) begin
			wr_ptr_q <= PTR_W'(wr_ptr_q + 1'b1);
			if (fill_q < DLY_W'(MAX_DELAY_SAMPLES)) begin
				fill_q <= DLY_W'(fill_q + 12'h001);
			end
		end
	end

	assign past = hist[PTR_W'(wr_ptr_q - PTR_W'(dly_q))];

	always_comb begin
		delayed = '0;
		if (dly_q == '0) begin
			delayed = in_pair;
		end else if (dly_q <= fill_q) begin
			delayed = past;
		end
		aligned = in_pair;
		if (path_q == PATH_REF) begin
			aligned.echo_ref = delayed.echo_ref;
		end else begin
			aligned.mic = delayed.mic;
		end
	end

	rda_pair_buffer #(
		.WIDTH($bits(rda_pair_t))
	) u_buf (
		.mclk      (mclk),
		.rst       (rst),
		.in_valid  (in_valid),
		.in_ready  (buf_ready),
		.in_data   (aligned),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_pair)
	);

endmodule : rda_aligner

// ### core/rda_pair_buffer.sv
`timescale 1ns/1ps
module rda_pair_buffer #(
	parameter int unsigned WIDTH = 32
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	logic [WIDTH-1:0] head_q;
	logic [WIDTH-1:0] tail_q;
	logic             head_vld_q;
	logic             tail_vld_q;
	logic             rdy_q;
	logic             push;
	logic             pop;

	assign push      = in_valid && rdy_q;
	assign pop       = head_vld_q && out_ready;
	assign in_ready  = rdy_q;
	assign out_valid = head_vld_q;
	assign out_data  = head_q;

	// ****************************************************************
	// Two entries, head feeds the output
	// ****************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			head_vld_q <= 1'b0;
			tail_vld_q <= 1'b0;
			rdy_q      <= 1'b1;
		end else if (pop) begin
			head_vld_q <= tail_vld_q || push;
			tail_vld_q <= tail_vld_q && push;
			rdy_q      <= !(tail_vld_q && push);
		end else if (push) begin
			head_vld_q <= 1'b1;
			tail_vld_q <= head_vld_q;
			rdy_q      <= !head_vld_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (pop) begin
			if (tail_vld_q) begin
				head_q <= tail_q;
			end else if (push) begin
				head_q <= in_data;
			end
			if (tail_vld_q && push) begin
				tail_q <= in_data;
			end
		end else if (push) begin
			if (head_vld_q) begin
				tail_q <= in_data;
			end else begin
				head_q <= in_data;
			end
		end
	end

endmodule : rda_pair_buffer

// ### include/rda_pkg.sv
package rda_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned MAX_DELAY_MS      = 150;
	localparam int unsigned SAMPLE_RATE_KHZ   = 16;
	localparam int unsigned MAX_DELAY_SAMPLES = MAX_DELAY_MS * SAMPLE_RATE_KHZ;
	localparam int unsigned DLY_W             = 12;
	localparam int unsigned SAMPLE_W          = 16;
	localparam int unsigned ADDR_W            = 8;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] REG_FIXED   = 8'h04;
	localparam logic [ADDR_W-1:0] REG_TRIGGER = 8'h08;
	localparam logic [ADDR_W-1:0] REG_LEVEL   = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_QUIET   = 8'h10;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h14;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int unsigned CTRL_MODE_LSB  = 0;
	localparam int unsigned CTRL_PATH_BIT  = 2;
	localparam int unsigned TRIG_EST_BIT   = 0;
	localparam int unsigned TRIG_FIX_BIT   = 1;
	localparam int unsigned STAT_DLY_LSB   = 0;
	localparam int unsigned STAT_PATH_BIT  = 12;
	localparam int unsigned STAT_BUSY_BIT  = 13;
	localparam int unsigned STAT_VALID_BIT = 14;
	localparam int unsigned STAT_TMO_BIT   = 15;
	localparam int unsigned STAT_MODE_LSB  = 16;

	// ****************************************************************
	// Encodings and reset values
	// ****************************************************************
	localparam logic [1:0]          MODE_STARTUP = 2'h0;
	localparam logic [1:0]          MODE_AUTO    = 2'h1;
	localparam logic [1:0]          MODE_MANUAL  = 2'h2;
	localparam logic                PATH_REF     = 1'b0;
	localparam logic                PATH_MIC     = 1'b1;
	localparam logic [DLY_W-1:0]    FIXED_RST    = 12'h000;
	localparam logic [SAMPLE_W-1:0] LEVEL_RST    = 16'h0800;
	localparam logic [DLY_W-1:0]    QUIET_RST    = 12'h0A0;
	localparam logic [1:0]          RESP_OKAY    = 2'h0;
	localparam logic [1:0]          RESP_SLVERR  = 2'h2;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic [SAMPLE_W-1:0] echo_ref;
		logic [SAMPLE_W-1:0] mic;
	} rda_pair_t;

endpackage : rda_pkg

// ### tb/rda_checker.sv
`timescale 1ns/1ps
module rda_checker import rda_pkg::*; (
	input wire logic              mclk,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              in_valid,
	input wire logic              in_ready,
	input wire logic              out_valid,
	input wire logic              out_ready,
	input wire rda_pair_t         out_pair
);
	logic [ADDR_W-1:0] wa_q;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			wa_q <= '0;
		else if (s_axi_awvalid && s_axi_awready)
			wa_q <= s_axi_awaddr;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	chk_wr_resp:
	assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
		|=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid) else $error("write answer late");
	chk_wr_code:
	assert property (s_axi_bvalid |-> s_axi_bresp == ((wa_q == REG_CTRL || wa_q == REG_FIXED ||
		wa_q == REG_TRIGGER || wa_q == REG_LEVEL || wa_q == REG_QUIET) ? RESP_OKAY : RESP_SLVERR))
		else $error("write response code wrong");
	chk_b_hold:
	assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_rd_lat:
	assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	chk_r_hold:
	assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_out_lat:
	assert property (in_valid && in_ready && !out_valid |=> out_valid) else $error("output late");
	chk_out_hold:
	assert property (out_valid && !out_ready |=> out_valid && $stable(out_pair)) else $error("output not held");
	chk_full_ready:
	assert property (!in_ready |-> out_valid) else $error("refused while empty");
endmodule : rda_checker

bind rda_aligner rda_checker chk (.*);

// ### tb/rda_sink_model.sv
`timescale 1ns/1ps
// ********
// Stream sink: 0 prompt, 1 random stalls, 2 stopped
// ********
module rda_sink_model (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [1:0] mode,
	output logic            out_ready
);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			out_ready <= 1'b0;
		else
			out_ready <= (mode == 2'h0) || (mode == 2'h1 && $urandom_range(3) != 0);
	end
endmodule : rda_sink_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb import rda_pkg::*;;
	// ********
	// Signals
	// ********
	logic              mclk = 1'b0;
	logic              rst = 1'b1;
	logic [ADDR_W-1:0] s_axi_awaddr = '0;
	logic [ADDR_W-1:0] s_axi_araddr = '0;
	logic [31:0]       s_axi_wdata = '0;
	logic [3:0]        s_axi_wstrb = 4'hF;
	logic              s_axi_awvalid = 1'b0;
	logic              s_axi_wvalid = 1'b0;
	logic              s_axi_bready = 1'b0;
	logic              s_axi_arvalid = 1'b0;
	logic              s_axi_rready = 1'b0;
	logic              in_valid = 1'b0;
	rda_pair_t         in_pair = '0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic              in_ready, out_valid, out_ready;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic [31:0]       s_axi_rdata;
	rda_pair_t         out_pair;
	logic [1:0]        sink_mode = 2'h0;
	int                errors = 0;
	int                n_checks = 0;
	int                cur_d = 0;
	logic              cur_path = PATH_REF;
	bit                chk_on = 0;
	rda_pair_t         hist[$];
	rda_pair_t         exp_q[$];
	logic [31:0]       v;
	logic [1:0]        r;
	int                cnt;
	logic [7:0]        ra[6] = '{REG_CTRL, REG_FIXED, REG_LEVEL, REG_QUIET, REG_TRIGGER, 8'h40};
	logic [31:0]       rv[6] = '{32'h0, 32'h0, 32'h800, 32'hA0, 32'h0, 32'h0};

	always #2 mclk = ~mclk;

	rda_aligner #(.DEPTH(4096)) uut (.*);
	rda_sink_model sink (.mclk(mclk), .rst(rst), .mode(sink_mode), .out_ready(out_ready));

	// ********
	// Tasks
	// ********
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic fail(input string m);
		$display("ERROR %0t %s", $time, m);
		errors++;
	endtask : fail

	task automatic hang();
		fail("timeout");
		give_verdict();
	endtask : hang

	task automatic cmp32(input logic [31:0] g, input logic [31:0] e, input string m);
		n_checks++;
		if (g !== e)
			fail(m);
	endtask : cmp32

	task automatic cmp_pair(input rda_pair_t g, input rda_pair_t e);
		n_checks++;
		if (g !== e)
			fail("pair mismatch");
	endtask : cmp_pair

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		int t;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'($urandom);
		for (t = 0; t < 50; t++) begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bready && s_axi_bvalid)
				break;
			s_axi_bready <= 1'b1;
		end
		if (t == 50)
			hang();
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
		int t;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'($urandom);
		for (t = 0; t < 50; t++) begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rready && s_axi_rvalid)
				break;
			s_axi_rready <= 1'b1;
		end
		if (t == 50)
			hang();
		d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic chk_status(input int d, input logic p, input logic [1:0] m, input logic ok);
		logic [31:0] s;
		logic [1:0]  rs;
		int          t;
		for (t = 0; t < 20; t++) begin
			rd(REG_STATUS, s, rs);
			if (s[11:0] == d[11:0])
				break;
		end
		cmp32(s & 32'hFFFF_DFFF, {14'h0, m, 1'b0, ok, 1'b0, p, d[11:0]}, "status");
	endtask : chk_status

	task automatic wait_take();
		int t;
		for (t = 0; t < 400; t++) begin
			@(posedge mclk);
			if (in_ready)
				break;
		end
		if (t == 400)
			hang();
	endtask : wait_take

	task automatic send(input rda_pair_t p);
		in_valid <= 1'b1;
		in_pair <= p;
		wait_take();
	endtask : send

	task automatic burst(input int n);
		@(posedge mclk);
		repeat (n) begin
			if ($urandom_range(3) == 0) begin
				in_valid <= 1'b0;
				@(posedge mclk);
			end
			send(rda_pair_t'($urandom));
		end
		in_valid <= 1'b0;
	endtask : burst

	// Quiet lead-in, onset on the leading channel, follower lag samples later
	task automatic feed(input bit ref_lead, input int lag);
		@(posedge mclk);
		repeat (4) send('0);
		send(ref_lead ? {16'h1000, 16'h0000} : {16'h0000, 16'h1000});
		repeat (lag - 1) send('0);
		send(ref_lead ? {16'h0000, 16'h1000} : {16'h1000, 16'h0000});
		repeat (4) send('0);
		in_valid <= 1'b0;
	endtask : feed

	task automatic drain();
		int t;
		for (t = 0; t < 300; t++) begin
			@(posedge mclk);
			if (!out_valid && exp_q.size() == 0)
				break;
		end
		if (t == 300)
			hang();
	endtask : drain

	function automatic rda_pair_t exp_pair(input int n);
		rda_pair_t e;
		rda_pair_t s;
		e = hist[n];
		s = (n >= cur_d) ? hist[n - cur_d] : '0;
		if (cur_path == PATH_MIC)
			e.mic = s.mic;
		else
			e.echo_ref = s.echo_ref;
		return e;
	endfunction : exp_pair

	always @(posedge mclk) begin
		if (!rst && in_valid && in_ready) begin
			hist.push_back(in_pair);
			if (chk_on)
				exp_q.push_back(exp_pair(hist.size() - 1));
		end
		if (chk_on && out_valid && out_ready) begin
			if (exp_q.size() == 0)
				fail("unexpected output");
			else
				cmp_pair(out_pair, exp_q.pop_front());
		end
	end

	// ********
	// Sequence
	// ********
	initial begin
		void'($urandom(51970));
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		foreach (ra[i]) begin
			rd(ra[i], v, r);
			cmp32(v, rv[i], "reset value");
		end
		cmp32(32'(r), 32'(RESP_SLVERR), "unmapped read");
		chk_status(0, PATH_REF, MODE_STARTUP, 1'b0);
		wr(REG_STATUS, 32'h1, r);
		cmp32(32'(r), 32'(RESP_SLVERR), "status write");
		wr(8'h40, 32'h1, r);
		cmp32(32'(r), 32'(RESP_SLVERR), "unmapped write");
		s_axi_wstrb <= 4'h2;
		wr(REG_LEVEL, 32'hAA09_07BB, r);
		s_axi_wstrb <= 4'hF;
		rd(REG_LEVEL, v, r);
		cmp32(v, 32'h0000_0700, "byte strobe");
		wr(REG_QUIET, 32'h2, r);
		feed(1, 37);
		chk_status(37, PATH_REF, MODE_STARTUP, 1'b1);
		feed(0, 20);
		chk_status(37, PATH_REF, MODE_STARTUP, 1'b1);
		wr(REG_CTRL, 32'(MODE_AUTO), r);
		feed(0, 55);
		chk_status(55, PATH_MIC, MODE_AUTO, 1'b1);
		feed(1, 12);
		chk_status(12, PATH_REF, MODE_AUTO, 1'b1);
		wr(REG_CTRL, 32'h7, r);
		rd(REG_CTRL, v, r);
		cmp32(v, 32'h5, "mode 3 ignored");
		wr(REG_CTRL, 32'h6, r);
		feed(1, 30);
		chk_status(12, PATH_REF, MODE_MANUAL, 1'b1);
		wr(REG_TRIGGER, 32'h1, r);
		feed(1, 30);
		chk_status(30, PATH_REF, MODE_MANUAL, 1'b1);
		wr(REG_FIXED, 32'd300, r);
		chk_status(300, PATH_MIC, MODE_MANUAL, 1'b1);
		cur_d = 300;
		cur_path = PATH_MIC;
		chk_on = 1;
		sink_mode <= 2'h1;
		burst(500);
		drain();
		sink_mode <= 2'h2;
		repeat (2) @(posedge mclk);
		cnt = 0;
		in_valid <= 1'b1;
		in_pair <= rda_pair_t'($urandom);
		repeat (8) begin
			@(posedge mclk);
			if (in_ready) begin
				cnt++;
				in_pair <= rda_pair_t'($urandom);
			end
		end
		cmp32(32'(cnt), 32'h2, "buffer fill");
		sink_mode <= 2'h1;
		wait_take();
		in_valid <= 1'b0;
		drain();
		chk_on = 0;
		wr(REG_CTRL, 32'(MODE_MANUAL), r);
		wr(REG_FIXED, 32'hFFF, r);
		wr(REG_TRIGGER, 32'h2, r);
		chk_status(2400, PATH_REF, MODE_MANUAL, 1'b1);
		cur_d = 2400;
		cur_path = PATH_REF;
		chk_on = 1;
		burst(2600);
		drain();
		give_verdict();
	end
endmodule : tb
